// file: flash_guard_host.sv
// host controller that drives the protection features of a parallel nor flash over its pins
// Notes on behaviour
// - host protects and unprotects only with the reset pin at high voltage.
// - host refuses to unprotect unless every unit is already protected.
// - unprotect clears all units at once; host re-protects none of them afterwards.
// - the guard pin is always driven to a defined level.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "flash_guard_defines.svh"
module flash_guard_host #(
	parameter bit          FACTORY_LOCKED = 1'b0,
	parameter int unsigned RESET_CYC      = `FG_RESET_CYC
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire flash_guard_pkg::apb_req_type apbReq,
	output      flash_guard_pkg::apb_rsp_type apbRsp,
	input  wire logic [15:0]                  dqIn,
	output      flash_guard_pkg::flash_pins_type pins
);
	localparam int ACCESS_CYC  = `FG_ACCESS_CYC + `FG_SYNC_CYC;
	localparam int WE_CYC      = `FG_WE_CYC;
	localparam int RECOVER_CYC = `FG_RECOVER_CYC;
	localparam int UNITS       = `FG_UNIT_COUNT;

	typedef enum logic [2:0] {IDLE, SETUP, PULSE, RECOVER, RSTPULSE} state_type;

	state_type             state_q;
	flash_guard_pkg::op_type opQ;
	logic [1:0]            ctrl_q;
	logic [19:0]           addr_q;
	logic [15:0]           wdata_q;
	logic [15:0]           rdata_q;
	logic [UNITS-1:0]      prot_q;
	logic                  secMode_q;
	logic                  secLocked_q;
	logic                  err_q;
	logic [15:0]           cnt_q;
	logic [15:0]           dqS1_q;
	logic [15:0]           dqS2_q;
	logic [15:0]           dqS3_q;
	logic                  busy;
	logic                  apbWrite;
	logic                  apbRead;
	logic                  mapped;
	logic                  cmdWrite;
	logic                  cmdOk;
	logic [4:0]            unitIdx;
	logic                  predictBlock;
	logic                  wpHigh;
	logic                  hvOn;
	flash_guard_pkg::op_type cmdOp;

	assign wpHigh   = ctrl_q[`FG_CTRL_WP_BIT];
	assign hvOn     = ctrl_q[`FG_CTRL_HV_BIT];
	assign busy     = (state_q != IDLE);
	assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign apbRead  = apbReq.psel && apbReq.penable && !apbReq.pwrite;
	assign cmdOp    = flash_guard_pkg::op_type'(apbReq.pwdata[2:0]);
	assign cmdWrite = apbWrite && (apbReq.paddr == `FG_OFF_CMD);

	// unit index: 0 SA0, 1 SA1-3, 2..7 four-sector blocks, 8 SA28-30, 9..16 small sectors
	function automatic logic [4:0] unitOf(input logic [7:0] a);
		if (a[7:3] == 5'h00) begin
			unitOf = 5'd0;
		end else if (a[7:5] == 3'h0) begin
			unitOf = 5'd1;
		end else if (a[7:3] == 5'h1F) begin
			unitOf = 5'd9 + {2'h0, a[2:0]};
		end else if (a[7:5] == 3'h7) begin
			unitOf = 5'd8;
		end else begin
			unitOf = {2'h0, a[7:5]} + 5'd1;
		end
	endfunction

	assign unitIdx = unitOf(addr_q[19:12]);

	// mirror of what the device will refuse, so software can skip doomed writes
	always_comb begin
		predictBlock = 1'b0;
		if (secMode_q && addr_q[19:15] == `FG_SECURE_TOP5) begin
			predictBlock = FACTORY_LOCKED || secLocked_q;
		end else if (!wpHigh && (addr_q[19:12] == `FG_OUTER_A
				|| addr_q[19:12] == `FG_OUTER_B)) begin
			predictBlock = 1'b1;
		end else begin
			predictBlock = prot_q[unitIdx] && !hvOn;
		end
	end

	// protection ops are refused without high voltage; unprotect needs every unit set first
	always_comb begin
		cmdOk = !busy;
		if (cmdOp == flash_guard_pkg::OP_PROTECT) begin
			cmdOk = !busy && hvOn;
		end else if (cmdOp == flash_guard_pkg::OP_UNPROTECT) begin
			cmdOk = !busy && hvOn && (&prot_q) && !secMode_q;
		end
	end

	always_comb begin
		unique case (apbReq.paddr)
			`FG_OFF_CTRL, `FG_OFF_ADDR, `FG_OFF_WDATA, `FG_OFF_CMD,
			`FG_OFF_STATUS, `FG_OFF_RDATA, `FG_OFF_PROT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		apbRsp.pready  = 1'b1;
		apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;
		apbRsp.prdata  = 32'h0000_0000;
		if (apbRead) begin
			unique case (apbReq.paddr)
				`FG_OFF_CTRL:   apbRsp.prdata = {30'h0, ctrl_q};
				`FG_OFF_ADDR:   apbRsp.prdata = {12'h000, addr_q};
				`FG_OFF_WDATA:  apbRsp.prdata = {16'h0000, wdata_q};
				`FG_OFF_STATUS: apbRsp.prdata = {27'h0, secLocked_q, predictBlock,
					err_q, secMode_q, busy};
				`FG_OFF_RDATA:  apbRsp.prdata = {16'h0000, rdata_q};
				`FG_OFF_PROT:   apbRsp.prdata = {15'h0000, prot_q};
				default:        apbRsp.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q  <= `FG_CTRL_RESET;
			addr_q  <= 20'h0_0000;
			wdata_q <= 16'h0000;
		end else if (apbWrite) begin
			if (apbReq.paddr == `FG_OFF_CTRL) begin
				ctrl_q <= apbReq.pwdata[1:0];
			end
			if (apbReq.paddr == `FG_OFF_ADDR && !busy) begin
				addr_q <= apbReq.pwdata[19:0];
			end
			if (apbReq.paddr == `FG_OFF_WDATA && !busy) begin
				wdata_q <= apbReq.pwdata[15:0];
			end
		end
	end

	// sticky refusal flag; a new refusal in the clearing cycle wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_q <= 1'b0;
		end else if (cmdWrite && !cmdOk) begin
			err_q <= 1'b1;
		end else if (apbWrite && apbReq.paddr == `FG_OFF_STATUS
				&& apbReq.pwdata[`FG_ST_ERR_BIT]) begin
			err_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dqS1_q <= 16'h0000;
			dqS2_q <= 16'h0000;
			dqS3_q <= 16'h0000;
		end else begin
			dqS1_q <= dqIn;
			dqS2_q <= dqS1_q;
			dqS3_q <= dqS2_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= IDLE;
			opQ     <= flash_guard_pkg::OP_NOP;
			cnt_q   <= 16'h0000;
			rdata_q <= 16'h0000;
		end else begin
			unique case (state_q)
				IDLE: begin
					if (cmdWrite && cmdOk) begin
						opQ <= cmdOp;
						unique case (cmdOp)
							flash_guard_pkg::OP_READ, flash_guard_pkg::OP_WRITE,
							flash_guard_pkg::OP_PROTECT,
							flash_guard_pkg::OP_UNPROTECT: state_q <= SETUP;
							flash_guard_pkg::OP_HW_RESET: begin
								state_q <= RSTPULSE;
								cnt_q   <= 16'(RESET_CYC - 1);
							end
							default: state_q <= IDLE;
						endcase
					end
				end
				SETUP: begin
					state_q <= PULSE;
					cnt_q   <= (opQ == flash_guard_pkg::OP_READ) ?
						16'(ACCESS_CYC - 1) : 16'(WE_CYC - 1);
				end
				PULSE: begin
					if (cnt_q != 16'h0000) begin
						cnt_q <= cnt_q - 16'h0001;
					end else if (opQ != flash_guard_pkg::OP_READ || dqS2_q == dqS3_q) begin
						if (opQ == flash_guard_pkg::OP_READ) begin
							rdata_q <= dqS3_q;
						end
						state_q <= RECOVER;
						cnt_q   <= 16'(RECOVER_CYC - 1);
					end
				end
				RECOVER, RSTPULSE: begin
					if (cnt_q != 16'h0000) begin
						cnt_q <= cnt_q - 16'h0001;
					end else begin
						state_q <= IDLE;
					end
				end
				default: state_q <= IDLE;
			endcase
		end
	end

	// shadow of the nonvolatile protection bits, updated when the cycle completes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prot_q <= `FG_PROT_RESET;
		end else if (state_q == RECOVER && cnt_q == 16'h0000) begin
			if (opQ == flash_guard_pkg::OP_PROTECT && !secMode_q) begin
				prot_q[unitIdx] <= 1'b1;
			end else if (opQ == flash_guard_pkg::OP_UNPROTECT) begin
				prot_q <= '0;
			end
		end
	end

	// the secured lock survives hardware reset but rst reloads it from FACTORY_LOCKED; mapping ends on exit or hardware reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			secMode_q   <= 1'b0;
			secLocked_q <= FACTORY_LOCKED;
		end else begin
			if (state_q == RECOVER && cnt_q == 16'h0000
					&& opQ == flash_guard_pkg::OP_PROTECT && secMode_q) begin
				secLocked_q <= 1'b1;
			end
			if (cmdWrite && cmdOk && cmdOp == flash_guard_pkg::OP_SEC_ENTER) begin
				secMode_q <= 1'b1;
			end else if ((cmdWrite && cmdOk && cmdOp == flash_guard_pkg::OP_SEC_EXIT)
					|| state_q == RSTPULSE) begin
				secMode_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins <= '{addr: 20'h0_0000, chipEnableN: 1'b1, outEnableN: 1'b1,
				writeEnableN: 1'b1, dqOut: 16'h0000, dqOe: 1'b0, resetN: 1'b1,
				highVoltageLevel: 1'b0, writeGuardAccelPin: 1'b0};
		end else begin
			pins.writeGuardAccelPin <= wpHigh;
			pins.highVoltageLevel   <= hvOn && state_q != RSTPULSE;
			pins.resetN             <= !(state_q == IDLE && cmdWrite && cmdOk
				&& cmdOp == flash_guard_pkg::OP_HW_RESET) && !(state_q == RSTPULSE
				&& cnt_q != 16'h0000);
			pins.addr               <= addr_q;
			pins.dqOut              <= wdata_q;
			pins.chipEnableN        <= !(state_q == SETUP || state_q == PULSE);
			pins.dqOe               <= opQ != flash_guard_pkg::OP_READ
				&& (state_q == SETUP || state_q == PULSE);
			pins.outEnableN         <= !(state_q == PULSE && opQ == flash_guard_pkg::OP_READ);
			// no accelerate level is ever applied, so the secured region never sees it
			pins.writeEnableN       <= !(state_q == PULSE && opQ != flash_guard_pkg::OP_READ
				&& cnt_q != 16'h0000);
		end
	end

	AST_UNPROTECT_ONLY_ALL_SET: assert property (@(posedge clk) disable iff (rst)
		(state_q == IDLE && $past(state_q) == IDLE && busy == 1'b0 ##1
			state_q == SETUP && opQ == flash_guard_pkg::OP_UNPROTECT) |-> &$past(prot_q))
		else $error("unprotect started with a unit still unprotected");
	AST_HV_DURING_PROTECT: assert property (@(posedge clk) disable iff (rst)
		(state_q == PULSE && (opQ == flash_guard_pkg::OP_PROTECT
			|| opQ == flash_guard_pkg::OP_UNPROTECT)) |-> ##1 pins.highVoltageLevel)
		else $error("protection cycle without high voltage on reset");
	AST_UNPROTECT_CLEARS_ALL: assert property (@(posedge clk) disable iff (rst)
		(state_q == RECOVER && cnt_q == 16'h0000 && opQ == flash_guard_pkg::OP_UNPROTECT)
			|=> prot_q == '0)
		else $error("unprotect left units set");
	AST_GUARD_PIN_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
		$changed(wpHigh) |=> pins.writeGuardAccelPin == $past(wpHigh))
		else $error("guard pin did not follow control");
	AST_OUTER_BOOT_BLOCKED: assert property (@(posedge clk) disable iff (rst)
		(!wpHigh && !secMode_q && addr_q[19:13] == 7'h7F) |-> predictBlock)
		else $error("outer boot sector not blocked with guard low");
	AST_WRITE_PULSE_WIDTH: assert property (@(posedge clk) disable iff (rst)
		$fell(pins.writeEnableN) |-> (!pins.writeEnableN)[*8])
		else $error("write pulse too short");
	AST_RESET_ENDS_SECURED: assert property (@(posedge clk) disable iff (rst)
		$fell(pins.resetN) |-> ##[1:2] !secMode_q)
		else $error("secured mapping survived hardware reset");
	AST_REFUSAL_FLAGGED: assert property (@(posedge clk) disable iff (rst)
		(cmdWrite && !cmdOk) |=> err_q && ($past(busy) || state_q == IDLE))
		else $error("refused command not flagged");
	AST_STROBES_EXCLUSIVE: assert property (@(posedge clk) disable iff (rst)
		!(!pins.outEnableN && !pins.writeEnableN))
		else $error("read and write strobes low together");
	AST_HV_RESTORES_BLOCK: assert property (@(posedge clk) disable iff (rst)
		($fell(hvOn) && prot_q[unitIdx] && !secMode_q) |-> predictBlock)
		else $error("protected unit not blocked after high voltage removed");
endmodule

// file: flash_guard_defines.svh
// register offsets, field positions, reset values and timing counts of the flash guard host
`ifndef FLASH_GUARD_DEFINES_SVH
`define FLASH_GUARD_DEFINES_SVH
`define FG_OFF_CTRL        12'h000
`define FG_OFF_ADDR        12'h004
`define FG_OFF_WDATA       12'h008
`define FG_OFF_CMD         12'h00C
`define FG_OFF_STATUS      12'h010
`define FG_OFF_RDATA       12'h014
`define FG_OFF_PROT        12'h018
`define FG_CTRL_WP_BIT     0
`define FG_CTRL_HV_BIT     1
`define FG_ST_BUSY_BIT     0
`define FG_ST_SEC_BIT      1
`define FG_ST_ERR_BIT      2
`define FG_ST_BLOCK_BIT    3
`define FG_ST_SECLOCK_BIT  4
`define FG_CTRL_RESET      2'h0
`define FG_PROT_RESET      17'h0_0000
`define FG_CLK_PERIOD_PS   4000
`define FG_ACCESS_NS       85
`define FG_WE_PULSE_NS     35
`define FG_RECOVER_NS      20
`define FG_RESET_PULSE_NS  500
`define FG_ACCESS_CYC      ((`FG_ACCESS_NS * 1000 + `FG_CLK_PERIOD_PS - 1) / `FG_CLK_PERIOD_PS)
`define FG_WE_CYC          ((`FG_WE_PULSE_NS * 1000 + `FG_CLK_PERIOD_PS - 1) / `FG_CLK_PERIOD_PS)
`define FG_RECOVER_CYC     ((`FG_RECOVER_NS * 1000 + `FG_CLK_PERIOD_PS - 1) / `FG_CLK_PERIOD_PS)
`define FG_RESET_CYC       ((`FG_RESET_PULSE_NS * 1000 + `FG_CLK_PERIOD_PS - 1) / `FG_CLK_PERIOD_PS)
`define FG_SYNC_CYC        3
`define FG_UNIT_COUNT      17
`define FG_SMALL_BASE      8'hF8
`define FG_OUTER_A         8'hFE
`define FG_OUTER_B         8'hFF
`define FG_SECURE_TOP5     5'h1F
`endif

// file: flash_guard_pkg.sv
// types shared by the flash guard host
package flash_guard_pkg;
	typedef enum logic [2:0] {
		OP_NOP,
		OP_READ,
		OP_WRITE,
		OP_PROTECT,
		OP_UNPROTECT,
		OP_SEC_ENTER,
		OP_SEC_EXIT,
		OP_HW_RESET
	} op_type;

	typedef struct packed {
		logic [19:0] addr;
		logic        chipEnableN;
		logic        outEnableN;
		logic        writeEnableN;
		logic [15:0] dqOut;
		logic        dqOe;
		logic        resetN;
		logic        highVoltageLevel;
		logic        writeGuardAccelPin;
	} flash_pins_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_type;
endpackage

// file: flash_model.sv
// behavioural flash device behind the host pins
`timescale 1ns/1ps
module flash_model #(
	parameter logic [15:0] PROT_WORD      = 16'h0001,
	parameter logic [15:0] UNPROT_WORD    = 16'h0040,
	parameter logic [15:0] ENTER_WORD     = 16'h0088,
	parameter logic [15:0] EXIT_WORD      = 16'h0090,
	parameter logic [15:0] SERIAL_BASE    = 16'h5A00, // arbitrary value
	parameter bit          FACTORY_LOCKED = 1'b0
) (
	input  wire logic                            clk,
	input  wire flash_guard_pkg::flash_pins_type pins,
	output      logic [15:0]                     dqIn
);
	logic [16:0] prot    = 17'h0_0000;
	logic        secMode = 1'b0;
	logic        secLock = FACTORY_LOCKED;
	logic [15:0] mem [int];
	logic [15:0] lastVal = 16'h0000;
	logic [15:0] rdVal   = 16'h0000;
	logic        drive;

	function automatic int unitOf(input logic [7:0] s);
		if (s[7:3] == 5'h00) return 0;
		if (s[7:5] == 3'h0) return 1;
		if (s[7:3] == 5'h1F) return 9 + s[2:0];
		if (s[7:3] >= 5'h1C) return 8;
		return s[7:5] + 1;
	endfunction

	function automatic bit blocked(input logic [19:0] w);
		if (w[19:13] == 7'h7F && !pins.writeGuardAccelPin) return 1'b1;
		return prot[unitOf(w[19:12])] && !pins.highVoltageLevel;
	endfunction

	function automatic logic [15:0] peek(input logic [19:0] w);
		if (secMode && w[19:15] == 5'h1F) begin
			if (w[19:3] == 17'h1_F000) return SERIAL_BASE + w[2:0];
			return mem.exists({1'b1, w}) ? mem[{1'b1, w}] : 16'hFFFF;
		end
		return mem.exists(w) ? mem[w] : 16'hFFFF;
	endfunction

	// hardware reset drops the secured mapping
	always @(posedge pins.writeEnableN or negedge pins.resetN) begin
		if (!pins.resetN) begin
			secMode = 1'b0;
		end else if (!pins.chipEnableN) begin
			if (pins.dqOut == ENTER_WORD) secMode = 1'b1;
			else if (pins.dqOut == EXIT_WORD) secMode = 1'b0;
			else if (pins.highVoltageLevel && pins.dqOut == PROT_WORD) begin
				if (secMode) secLock = 1'b1;
				else prot[unitOf(pins.addr[19:12])] = 1'b1;
			end else if (pins.highVoltageLevel && pins.dqOut == UNPROT_WORD) prot = '0;
			else if (secMode && pins.addr[19:15] == 5'h1F) begin
				if (!secLock) mem[{1'b1, pins.addr}] = pins.dqOut;
			end else if (!blocked(pins.addr)) mem[pins.addr] = pins.dqOut;
		end
	end

	// released bus shows the inverse of the last value, never a stale copy
	assign drive = !pins.chipEnableN && !pins.outEnableN && pins.resetN;
	assign dqIn  = drive ? rdVal : ~lastVal;
	always @(posedge clk) begin
		rdVal <= peek(pins.addr);
		if (drive) lastVal <= rdVal;
	end
endmodule

// file: flash_guard_host_tb_top.sv
// self-checking bench for the flash guard host against a behavioural flash
`timescale 1ns/1ps
`include "flash_guard_defines.svh"
module flash_guard_host_tb_top;
	logic                            clk;
	logic                            rst;
	flash_guard_pkg::apb_req_type    apbReq;
	flash_guard_pkg::apb_rsp_type    apbRsp;
	logic [15:0]                     dqIn;
	flash_guard_pkg::flash_pins_type pins;
	int                              mismatches;
	int                              cmp_count;
	logic [31:0]                     rd;
	logic                            err;
	logic [7:0]                      unitSel [17] = '{8'h00, 8'h08, 8'h20, 8'h40, 8'h60, 8'h80,
		8'hA0, 8'hC0, 8'hE0, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF};

	flash_guard_host #(.FACTORY_LOCKED(1'b0), .RESET_CYC(4)) i_dut (
		.clk    (clk),
		.rst    (rst),
		.apbReq (apbReq),
		.apbRsp (apbRsp),
		.dqIn   (dqIn),
		.pins   (pins)
	);
	flash_model i_flash (.clk(clk), .pins(pins), .dqIn(dqIn));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge clk);
		end while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
	endtask

	task automatic op(input flash_guard_pkg::op_type code);
		apb(1'b1, `FG_OFF_CMD, {29'h0, code});
		do begin
			apb(1'b0, `FG_OFF_STATUS, 32'h0);
		end while (rd[`FG_ST_BUSY_BIT] !== 1'b0);
	endtask

	task automatic xfer(input logic [19:0] a, input logic [15:0] d,
			input flash_guard_pkg::op_type code);
		apb(1'b1, `FG_OFF_ADDR, {12'h0, a});
		apb(1'b1, `FG_OFF_WDATA, {16'h0, d});
		op(code);
	endtask

	task automatic rdw(input logic [19:0] a);
		xfer(a, 16'h0, flash_guard_pkg::OP_READ);
		apb(1'b0, `FG_OFF_RDATA, 32'h0);
	endtask

	task automatic stat(input logic [19:0] a);
		apb(1'b1, `FG_OFF_ADDR, {12'h0, a});
		apb(1'b0, `FG_OFF_STATUS, 32'h0);
	endtask

	initial begin
		#200_000;
		mismatches++;
		print_verdict();
	end

	initial begin
		apbReq = '0;
		rst = 1'b1;
		mismatches = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `FG_OFF_CTRL, 32'h0);
		check(rd, {30'h0, `FG_CTRL_RESET});
		check(pins.writeGuardAccelPin, 1'b0);
		apb(1'b0, `FG_OFF_PROT, 32'h0);
		check(rd, {15'h0, `FG_PROT_RESET});
		apb(1'b0, `FG_OFF_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 12'h0FC, 32'h0);
		check(rd, 32'h0);
		check(err, 1'b1);
		xfer(20'h2_0000, 16'h1234, flash_guard_pkg::OP_WRITE);
		rdw(20'h2_0000);
		check(rd, 32'h1234);
		xfer(20'h1_0000, 16'h0001, flash_guard_pkg::OP_PROTECT);
		check(rd[`FG_ST_ERR_BIT], 1'b1);
		apb(1'b1, `FG_OFF_STATUS, 32'h4);
		apb(1'b1, `FG_OFF_CTRL, 32'h3);
		xfer(20'h1_0000, 16'h0001, flash_guard_pkg::OP_PROTECT);
		apb(1'b0, `FG_OFF_PROT, 32'h0);
		check(rd, 32'h2);
		apb(1'b1, `FG_OFF_CTRL, 32'h1);
		stat(20'h1_8000);
		check(rd[`FG_ST_BLOCK_BIT], 1'b1);
		xfer(20'h1_8000, 16'hBEEF, flash_guard_pkg::OP_WRITE);
		rdw(20'h1_8000);
		check(rd, 32'hFFFF);
		apb(1'b1, `FG_OFF_CTRL, 32'h3);
		xfer(20'h1_8000, 16'hBEEF, flash_guard_pkg::OP_WRITE);
		apb(1'b1, `FG_OFF_CTRL, 32'h1);
		rdw(20'h1_8000);
		check(rd, 32'hBEEF);
		stat(20'h1_8000);
		check(rd[`FG_ST_BLOCK_BIT], 1'b1);
		apb(1'b1, `FG_OFF_CTRL, 32'h0);
		stat(20'hF_F000);
		check(rd[`FG_ST_BLOCK_BIT], 1'b1);
		apb(1'b1, `FG_OFF_CTRL, 32'h2);
		xfer(20'hF_F000, 16'h1111, flash_guard_pkg::OP_WRITE);
		rdw(20'hF_F000);
		check(rd, 32'hFFFF);
		apb(1'b1, `FG_OFF_CTRL, 32'h1);
		stat(20'hF_F000);
		check(rd[`FG_ST_BLOCK_BIT], 1'b0);
		xfer(20'hF_F000, 16'h1111, flash_guard_pkg::OP_WRITE);
		rdw(20'hF_F000);
		check(rd, 32'h1111);
		apb(1'b1, `FG_OFF_CTRL, 32'h3);
		xfer(20'h0_0000, 16'h0040, flash_guard_pkg::OP_UNPROTECT);
		check(rd[`FG_ST_ERR_BIT], 1'b1);
		apb(1'b1, `FG_OFF_STATUS, 32'h4);
		// every unit protected first, then all cleared together
		foreach (unitSel[i]) begin
			xfer({unitSel[i], 12'h0}, 16'h0001, flash_guard_pkg::OP_PROTECT);
		end
		apb(1'b0, `FG_OFF_PROT, 32'h0);
		check(rd, 32'h0001_FFFF);
		xfer(20'h0_0000, 16'h0040, flash_guard_pkg::OP_UNPROTECT);
		apb(1'b0, `FG_OFF_PROT, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, `FG_OFF_CTRL, 32'h1);
		xfer(20'hF_8000, 16'h0088, flash_guard_pkg::OP_WRITE);
		op(flash_guard_pkg::OP_SEC_ENTER);
		check(rd[`FG_ST_SEC_BIT], 1'b1);
		rdw(20'hF_8003);
		check(rd, 32'h5A03);
		// locking the secured region is one-way: later writes there are dropped
		apb(1'b1, `FG_OFF_CTRL, 32'h3);
		xfer(20'hF_9000, 16'h0001, flash_guard_pkg::OP_PROTECT);
		check(rd[`FG_ST_SECLOCK_BIT], 1'b1);
		apb(1'b1, `FG_OFF_CTRL, 32'h1);
		xfer(20'hF_9000, 16'h2222, flash_guard_pkg::OP_WRITE);
		check(rd[`FG_ST_BLOCK_BIT], 1'b1);
		rdw(20'hF_9000);
		check(rd, 32'hFFFF);
		op(flash_guard_pkg::OP_HW_RESET);
		check(rd[`FG_ST_SEC_BIT], 1'b0);
		rdw(20'hF_8003);
		check(rd, 32'hFFFF);
		print_verdict();
	end
endmodule
